//--- common/boot_loader_pkg.sv
// Constants, types and state encoding for the on-board flash boot loader
//
// Summary of operation
// - Boot when write-enable high, both selects low
// - Store received bytes FB80..FF7F, branch FB80
// - Time receive low period of zero bytes
// - Eight data bits, one stop, no parity
// - Send 00 after adjust, host answers 55
// - F780..FB7F reserved for the loader itself
// - Line high at reset end, 100-state settle
// - Erase all blocks if flash not blank
// - Branch clears enables, keeps rate, tx high
// - User mode: select B high, A low, enable high
// - No flash reads while software write enable set; the code raises flash_read_block one cycle after the bit sets
// - Pin change during reset changes the mode
package boot_loader_pkg;

    // ------------------------------------------------------------------
    // Register map (APB byte addresses)
    // ------------------------------------------------------------------
    localparam logic [12:0] STATUS_OFS   = 13'h0000;
    localparam logic [12:0] RATE_OFS     = 13'h0004;
    localparam logic [12:0] SERCTL_OFS   = 13'h0008;
    localparam logic [12:0] FLASHCTL_OFS = 13'h000c;
    localparam logic [12:0] COUNT_OFS    = 13'h0010;
    localparam logic [12:0] RAM_OFS      = 13'h1000;

    // ------------------------------------------------------------------
    // Memory layout and protocol values
    // ------------------------------------------------------------------
    localparam logic [15:0] RESERVED_BASE = 16'hf780;
    localparam logic [15:0] PROG_BASE     = 16'hfb80;
    localparam logic [15:0] PROG_LAST     = 16'hff7f;
    localparam int          PROG_BYTES    = 1024;
    localparam int          PROG_AW       = 10;
    localparam logic [7:0]  SYNC_BYTE     = 8'h00;
    localparam logic [7:0]  ACK_BYTE      = 8'h55;
    localparam int          LOW_BITS      = 9;
    localparam int          FRAME_BITS    = 10;

    // ------------------------------------------------------------------
    // Timing: settle delay in states, clock 50 MHz
    // ------------------------------------------------------------------
    localparam int SETTLE_STATES = 100;
    localparam int CLK_MHZ       = 50;
    localparam int SETTLE_CYC    = SETTLE_STATES;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic flash_write_enable_pin;
        logic mode_select_pin_b;
        logic mode_select_pin_a;
    } mode_pins_s;

    typedef struct packed {
        logic receive_enable_bit;
        logic transmit_enable_bit;
    } serial_control_reg_s;

    typedef enum logic [3:0] {
        S_OFF, S_SETTLE, S_HUNT, S_LOW, S_DIV, S_SEND,
        S_WAIT_ACK, S_CHECK, S_ERASE, S_LOAD, S_TIDY, S_RUN
    } loader_state_e;

endpackage : boot_loader_pkg

//--- src/prog_ram.sv
// Programming control program RAM window with registered read data
`timescale 1ns/1ps
module prog_ram
    import boot_loader_pkg::*;
#(
    parameter int AW = PROG_AW,
    parameter int DW = 8
) (
    // Clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // Write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    // Read port
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    // Array itself is not reset; contents are undefined until loaded
    always_ff @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end

endmodule : prog_ram

//--- src/boot_loader.sv
// Boot-mode loader: mode straps, baud measurement, handshake, erase, load, branch
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module boot_loader
    import boot_loader_pkg::*;
#(
    parameter int LOW_W  = 20,
    parameter int RATE_W = 16
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [12:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // Mode pins
    input  wire mode_pins_s        mode_pins,
    // Boot serial port
    input  wire logic              rx_line,
    output logic                   tx_line,
    output logic                   tx_oe,
    // Flash
    input  wire logic              flash_blank,
    input  wire logic              flash_erase_done,
    output logic                   flash_erase_all,
    output logic                   flash_read_block,
    // Mode and branch
    output logic                   boot_mode,
    output logic                   user_mode,
    output logic                   cpu_branch,
    output logic [15:0]            branch_addr
);

    loader_state_e          state;
    mode_pins_s             mode;
    logic                   mode_ok;
    serial_control_reg_s    serctl;
    logic                   software_write_enable_bit;
    logic [RATE_W-1:0]      bit_rate_reg;
    logic [LOW_W-1:0]       low_len;
    logic [LOW_W-1:0]       div_rem;
    logic [7:0]             settle_cnt;
    logic [PROG_AW:0]       load_cnt;
    logic                   is_boot;
    logic                   is_user;
    // Serial engines
    logic                   rx_busy;
    logic [3:0]             rx_idx;
    logic [RATE_W-1:0]      rx_cnt;
    logic [7:0]             rx_shift;
    logic                   rx_valid;
    logic                   tx_busy;
    logic [3:0]             tx_idx;
    logic [RATE_W-1:0]      tx_cnt;
    logic [FRAME_BITS-1:0]  tx_shift;
    logic                   tx_start;
    logic                   rx_prev;
    // Bus
    logic                   apb_wr;
    logic [7:0]             ram_rdata;

    assign is_boot = mode.flash_write_enable_pin && !mode.mode_select_pin_b
                     && !mode.mode_select_pin_a;
    assign is_user = mode.flash_write_enable_pin && mode.mode_select_pin_b
                     && !mode.mode_select_pin_a;
    assign apb_wr  = psel && penable && pwrite && pready;
    assign tx_start = (state == S_SEND) && !tx_busy && (tx_idx == 4'h0);

    // ------------------------------------------------------------------
    // Mode straps
    // ------------------------------------------------------------------
    // Pins are caught on the first edge after reset release; before that
    // the mode is held at zero by reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode    <= '0;
            mode_ok <= 1'b0;
        end else if (!mode_ok) begin
            mode    <= mode_pins;
            mode_ok <= 1'b1;
        end
    end

    // Mode outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_mode <= 1'b0;
            user_mode <= 1'b0;
        end else begin
            boot_mode <= mode_ok && is_boot;
            user_mode <= mode_ok && is_user;
        end
    end

    // ------------------------------------------------------------------
    // Loader sequence
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= S_OFF;
        end else begin
            case (state)
                S_OFF:      if (mode_ok && is_boot) state <= S_SETTLE;
                S_SETTLE:   if (settle_cnt == 8'(SETTLE_CYC - 1)) state <= S_HUNT;
                S_HUNT:     if (rx_prev && !rx_line) state <= S_LOW;
                S_LOW:      if (rx_line) state <= S_DIV;
                S_DIV:      if (div_rem < LOW_W'(LOW_BITS)) state <= S_SEND;
                S_SEND:     if (tx_idx == 4'(FRAME_BITS) && !tx_busy) state <= S_WAIT_ACK;
                S_WAIT_ACK: if (rx_valid && rx_shift == ACK_BYTE) state <= S_CHECK;
                S_CHECK:    state <= flash_blank ? S_LOAD : S_ERASE;
                S_ERASE:    if (flash_erase_done) state <= S_LOAD;
                S_LOAD:     if (load_cnt == (PROG_AW+1)'(PROG_BYTES)) state <= S_TIDY;
                S_TIDY:     state <= S_RUN;
                S_RUN:      state <= S_RUN;
                default:    state <= S_OFF;
            endcase
        end
    end

    // Settle counter after reset before the line is watched
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_cnt <= '0;
        end else if (state == S_SETTLE) begin
            settle_cnt <= settle_cnt + 8'h01;
        end
    end

    // Line history for the falling edge; tracks the line in every state so that
    // a line already low when settling ends is not timed from mid-byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_prev <= 1'b1;
        end else begin
            rx_prev <= rx_line;
        end
    end

    // Low period measurement and division by nine, rounded to nearest
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_len      <= '0;
            div_rem      <= '0;
            bit_rate_reg <= '0;
        end else begin
            case (state)
                S_HUNT: begin
                    low_len <= '0;
                end
                S_LOW: begin
                    low_len <= low_len + 1'b1;
                    div_rem <= low_len + LOW_W'(LOW_BITS / 2 + 1);
                    bit_rate_reg <= '0;
                end
                S_DIV: begin
                    if (div_rem >= LOW_W'(LOW_BITS)) begin
                        div_rem      <= div_rem - LOW_W'(LOW_BITS);
                        bit_rate_reg <= bit_rate_reg + 1'b1;
                    end
                end
                default: begin
                    // Kept across the branch; software may retune in user mode
                    if (apb_wr && paddr == RATE_OFS && state == S_OFF) begin
                        bit_rate_reg <= pwdata[RATE_W-1:0];
                    end
                end
            endcase
        end
    end

    // Serial enables: loader owns them until the branch, software after
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serctl <= '0;
        end else if (state == S_DIV && div_rem < LOW_W'(LOW_BITS)) begin
            serctl <= '{receive_enable_bit: 1'b1, transmit_enable_bit: 1'b1};
        end else if (state == S_TIDY) begin
            serctl <= '0;
        end else if (apb_wr && paddr == SERCTL_OFS && (state == S_OFF || state == S_RUN)) begin
            serctl <= pwdata[1:0];
        end
    end

    // Software write enable and flash read blocking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            software_write_enable_bit <= 1'b0;
            flash_read_block          <= 1'b0;
        end else begin
            if (apb_wr && paddr == FLASHCTL_OFS) begin
                software_write_enable_bit <= pwdata[0] && mode.flash_write_enable_pin;
            end
            flash_read_block <= software_write_enable_bit;
        end
    end

    // Erase request held until the flash reports completion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_erase_all <= 1'b0;
        end else begin
            flash_erase_all <= (state == S_CHECK && !flash_blank)
                               || (state == S_ERASE && !flash_erase_done);
        end
    end

    // ------------------------------------------------------------------
    // Receive engine: start, 8 data LSB first, stop
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_busy  <= 1'b0;
            rx_idx   <= '0;
            rx_cnt   <= '0;
            rx_shift <= '0;
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (!rx_busy) begin
                if (serctl.receive_enable_bit && !rx_line) begin
                    rx_busy <= 1'b1;
                    rx_idx  <= '0;
                    rx_cnt  <= bit_rate_reg >> 1;                            // Sample mid-bit
                end
            end else if (rx_cnt != '0) begin
                rx_cnt <= rx_cnt - 1'b1;
            end else begin
                rx_cnt <= bit_rate_reg - 1'b1;
                rx_idx <= rx_idx + 4'h1;
                if (rx_idx == 4'h0 && rx_line) begin
                    rx_busy <= 1'b0;                                         // Glitch, not a start
                end else if (rx_idx == 4'(FRAME_BITS - 1)) begin
                    rx_busy  <= 1'b0;
                    rx_valid <= rx_line;
                end else if (rx_idx != 4'h0) begin
                    rx_shift <= {rx_line, rx_shift[7:1]};
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Transmit engine: one frame per completion byte
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_busy  <= 1'b0;
            tx_idx   <= '0;
            tx_cnt   <= '0;
            tx_shift <= '1;
            tx_line  <= 1'b1;
            tx_oe    <= 1'b0;
        end else begin
            if (state == S_TIDY) begin
                tx_oe <= 1'b1;
            end else if (serctl.transmit_enable_bit) begin
                tx_oe <= 1'b1;
            end
            if (tx_start && serctl.transmit_enable_bit) begin
                tx_busy  <= 1'b1;
                tx_cnt   <= bit_rate_reg - 1'b1;
                tx_shift <= {1'b1, SYNC_BYTE, 1'b0};
                tx_line  <= 1'b0;
                tx_idx   <= 4'h1;
            end else if (tx_busy) begin
                if (tx_cnt != '0) begin
                    tx_cnt <= tx_cnt - 1'b1;
                end else if (tx_idx == 4'(FRAME_BITS)) begin
                    tx_busy <= 1'b0;
                    tx_line <= 1'b1;
                end else begin
                    tx_cnt   <= bit_rate_reg - 1'b1;
                    tx_line  <= tx_shift[tx_idx];
                    tx_idx   <= tx_idx + 4'h1;
                end
            end else if (state != S_SEND) begin
                tx_line <= 1'b1;                                             // Idle high
            end
        end
    end

    // ------------------------------------------------------------------
    // Program load and branch
    // ------------------------------------------------------------------
    // Bytes land from the window base upward; the reserved loader area
    // below it is never addressed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_cnt    <= '0;
            cpu_branch  <= 1'b0;
            branch_addr <= '0;
        end else begin
            if (state == S_LOAD && rx_valid) begin
                load_cnt <= load_cnt + 1'b1;
            end
            cpu_branch <= (state == S_TIDY);
            if (state == S_TIDY) begin
                branch_addr <= PROG_BASE;
            end
        end
    end

    prog_ram #(.AW(PROG_AW), .DW(8)) u_ram (
        .pclk    (pclk),
        .presetn (presetn),
        .we      (state == S_LOAD && rx_valid),
        .waddr   (load_cnt[PROG_AW-1:0]),
        .wdata   (rx_shift),
        .raddr   (paddr[PROG_AW+1:2]),
        .rdata   (ram_rdata)
    );

    // ------------------------------------------------------------------
    // APB slave: one wait state so RAM reads have time to settle
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= 1'b0;
            prdata  <= '0;
            if (psel && penable && !pready) begin
                if (paddr[12]) begin
                    prdata <= {24'h0, ram_rdata};
                end else begin
                    case (paddr)
                        STATUS_OFS:   prdata <= {22'h0, 4'(state), 1'b0, mode,
                                                  user_mode, boot_mode};
                        RATE_OFS:     prdata <= 32'(bit_rate_reg);
                        SERCTL_OFS:   prdata <= {30'h0, serctl};
                        FLASHCTL_OFS: prdata <= {31'h0, software_write_enable_bit};
                        COUNT_OFS:    prdata <= 32'(load_cnt);
                        default:      pslverr <= 1'b1;
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_boot_entry: assert property (@(posedge pclk) disable iff (!presetn)
        (state == S_OFF && mode_ok && is_boot) |=> state == S_SETTLE)
        else $error("boot straps did not start the loader");

    chk_strap_capture: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(mode_ok) |-> mode == $past(mode_pins))
        else $error("mode not taken from pins at release");

    chk_settle_len: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(state == S_HUNT) |-> $past(settle_cnt) == 8'(SETTLE_CYC - 1))
        else $error("settle delay length wrong");

    chk_rate_calc: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(state == S_SEND) |-> (32'(bit_rate_reg) * 9 <= 32'(low_len) + 4)
            && (32'(low_len) + 4 < 32'(bit_rate_reg) * 9 + 9))
        else $error("bit period not nearest ninth of low period");

    chk_erase_cause: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(flash_erase_all) |-> $past(state == S_CHECK && !flash_blank))
        else $error("erase requested without non-blank flash");

    chk_branch_tidy: assert property (@(posedge pclk) disable iff (!presetn)
        cpu_branch |-> !serctl.receive_enable_bit && !serctl.transmit_enable_bit
            && tx_line && tx_oe && bit_rate_reg == $past(bit_rate_reg, 2))
        else $error("serial port not tidied at branch");

    chk_branch_addr: assert property (@(posedge pclk) disable iff (!presetn)
        cpu_branch |-> branch_addr == PROG_BASE && load_cnt == (PROG_AW+1)'(PROG_BYTES))
        else $error("branch before full load or to wrong address");

    chk_flash_block: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(software_write_enable_bit) |=> flash_read_block [*1] ##1 flash_read_block
            || !software_write_enable_bit)
        else $error("flash reads not blocked under write enable");

    chk_ack_frame: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(state == S_WAIT_ACK) |-> $past(tx_line) && !tx_busy)
        else $error("completion byte not fully sent");

endmodule : boot_loader

//--- tb/host_model.sv
// Host side of the boot serial link: zeros, sync answer, then the program image
`timescale 1ns/1ps
module host_model #(
    parameter int BIT = 6
) (
    // Clock and control
    input  wire logic       pclk,
    input  wire logic       go,
    input  wire logic       load_ok,
    // Serial lines
    input  wire logic       tx_line,
    output logic            rx_line,
    output logic [7:0]      reply,
    output logic            seen
);
    // One frame: start, eight data bits LSB first, stop, no parity
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_line <= f[i];
            repeat (BIT) @(posedge pclk);
        end
    endtask : send_byte

    // Zeros until the device answers; bit period cut to six clocks to keep the run short
    initial begin
        rx_line = 1'b1;
        wait (go);
        @(posedge pclk);
        while (!seen) send_byte(8'h00);
        send_byte(8'h55);
        wait (load_ok);
        @(posedge pclk);
        // Image is opaque data; its own start-up duties are not modelled
        for (int k = 0; k < 1024; k++) send_byte(k[7:0] ^ 8'ha5);
    end

    // Receiver samples each bit in its middle
    initial begin
        seen = 1'b0;
        reply = 8'hff;
        wait (go);
        @(negedge tx_line);
        repeat (BIT + BIT / 2) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            reply[i] = tx_line;
            repeat (BIT) @(posedge pclk);
        end
        seen <= 1'b1;
    end
endmodule : host_model

//--- tb/testbench.sv
// Self-checking bench: boot-mode load through the host model, then user mode
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
module testbench
    import boot_loader_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    localparam int BIT = 6;
    logic        pclk, pready, pslverr, tx_line, tx_oe, flash_erase_all, seen, err;
    logic        boot_mode, user_mode, cpu_branch, flash_read_block, flash_erase_done;
    logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
    logic        rx_line, erase_seen = 1'b0, load_ok = 1'b0;
    logic [12:0] paddr = 13'h0000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] branch_addr;
    logic [7:0]  reply;
    mode_pins_s  mode_pins = 3'b100;
    int          mismatches = 0, checks_done = 0;

    boot_loader u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .mode_pins(mode_pins), .rx_line(rx_line), .tx_line(tx_line),
        .tx_oe(tx_oe), .flash_blank(1'b0), .flash_erase_done(flash_erase_done),
        .flash_erase_all(flash_erase_all), .flash_read_block(flash_read_block),
        .boot_mode(boot_mode), .user_mode(user_mode), .cpu_branch(cpu_branch),
        .branch_addr(branch_addr));
    host_model #(.BIT(BIT)) u_host (.pclk(pclk), .go(go), .load_ok(load_ok),
        .tx_line(tx_line), .rx_line(rx_line), .reply(reply), .seen(seen));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // Flash answers an erase request one cycle later; load may follow once it ends
    always @(posedge pclk) begin
        flash_erase_done <= flash_erase_all;
        if (flash_erase_all === 1'b1) erase_seen <= 1'b1;
        load_ok <= erase_seen && flash_erase_all === 1'b0;
    end

    // APB master: waits for pready at the edge, never assumes a latency
    task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        go <= 1'b1;
        repeat (3) @(negedge pclk);
        `CHK("boot_mode", 1'b1, boot_mode)
        `CHK("user_mode", 1'b0, user_mode)
        apb(1'b0, STATUS_OFS, 32'h0);
        `CHK("status", 6'h11, rd[5:0])
        apb(1'b0, 13'h0020, 32'h0);
        `CHK("pslverr", 1'b1, err)
        apb(1'b1, RATE_OFS, 32'h77); // Refused while the loader owns the rate
        while (cpu_branch !== 1'b1) @(negedge pclk);
        `CHK("branch_addr", 16'hfb80, branch_addr)
        `CHK("tx_line", 1'b1, tx_line)
        `CHK("tx_oe", 1'b1, tx_oe)
        `CHK("sync", 8'h00, reply)
        `CHK("erase", 1'b1, erase_seen)
        apb(1'b0, RATE_OFS, 32'h0);
        `CHK("rate", 32'd6, rd)
        apb(1'b0, SERCTL_OFS, 32'h0);
        `CHK("serctl", 32'h0, rd)
        apb(1'b0, COUNT_OFS, 32'h0);
        `CHK("count", 32'd1024, rd)
        for (int i = 0; i < 1024; i += 341) begin
            apb(1'b0, RAM_OFS + 13'(4 * i), 32'h0);
            `CHK("ram", 8'(i) ^ 8'ha5, rd[7:0])
        end
        // Second reset with user-mode straps
        presetn <= 1'b0;
        mode_pins <= 3'b110;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(negedge pclk);
        `CHK("user_mode", 1'b1, user_mode)
        `CHK("boot_mode", 1'b0, boot_mode)
        apb(1'b1, RATE_OFS, 32'h1234);
        apb(1'b0, RATE_OFS, 32'h0);
        `CHK("user rate", 32'h1234, rd)
        apb(1'b1, FLASHCTL_OFS, 32'h1);
        repeat (2) @(negedge pclk);
        `CHK("read_block", 1'b1, flash_read_block)
        results();
    end

    // Watchdog: the load takes some 62k cycles
    initial begin
        repeat (90000) @(posedge pclk);
        mismatches++;
        results();
    end
endmodule : testbench
